/* File: rtl/pllc_pkg.sv */
// Shared constants, types and register layout of the fractional loop controller
package pllc_pkg;

  // Clocking of the register side
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned RATIO_SETTLE_NS = 1000;
  localparam int unsigned RATIO_SETTLE_CYC =
    (RATIO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Field widths
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned RATIO_INT_W = 12;
  localparam int unsigned FRAC_W      = 4;
  localparam int unsigned DIV_W       = 11;
  localparam int unsigned LOCK_TIME_SELECT_W     = 3;
  localparam int unsigned SETTLE_W    = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RATIO     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATE     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAG      = 8'h10;

  // Reset values and writable bits
  localparam logic [31:0] CONTROL_A_RST  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_B_RST  = 32'h0000_0000;
  localparam logic [31:0] RATIO_RST      = 32'h0000_0000;
  localparam logic [31:0] CONTROL_A_MASK = 32'h0000_0001;
  localparam logic [31:0] CONTROL_B_MASK = 32'h07ff_007f;
  localparam logic [31:0] RATIO_MASK     = 32'h000f_0fff;

  // Field positions
  localparam int unsigned LOOP_ON_BIT     = 0;
  localparam int unsigned REF_SEL_LSB     = 0;
  localparam int unsigned WAKE_FAST_BIT   = 2;
  localparam int unsigned LOCK_IGNORE_BIT = 3;
  localparam int unsigned LOCK_TIME_SELECT_LSB       = 4;
  localparam int unsigned DIV_LSB         = 16;
  localparam int unsigned RATIO_INT_LSB   = 0;
  localparam int unsigned RATIO_FRAC_LSB  = 16;
  localparam int unsigned FAIL_FLAG_BIT   = 0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register selector codes
  typedef enum logic [2:0] {
    PLLC_SEL_CTRL_A = 3'b000,
    PLLC_SEL_CTRL_B = 3'b001,
    PLLC_SEL_RATIO  = 3'b010,
    PLLC_SEL_STATE  = 3'b011,
    PLLC_SEL_FLAG   = 3'b100,
    PLLC_SEL_NONE   = 3'b111
  } pllc_sel_t;

  typedef enum logic [1:0] {
    PLLC_REF_SLOW_XTAL = 2'b00,
    PLLC_REF_MAIN_XTAL = 2'b01,
    PLLC_REF_GENERIC   = 2'b10,
    PLLC_REF_SPARE     = 2'b11
  } pllc_ref_src_t;

  typedef enum logic [1:0] {
    PLLC_OFF     = 2'b00,
    PLLC_STARTUP = 2'b01,
    PLLC_ACQUIRE = 2'b10,
    PLLC_RUN     = 2'b11
  } pllc_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pllc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pllc_axi_rsp_t;

  // Settings handed to the analog loop core
  typedef struct packed {
    logic                   loop_on;
    pllc_ref_src_t          ref_source_select;
    logic [DIV_W-1:0]       xosc_div;
    logic [RATIO_INT_W-1:0] ratio_integer;
    logic [FRAC_W-1:0]      ratio_sixteenths;
    logic                   fractional_mode;
  } pllc_core_cfg_t;

endpackage : pllc_pkg

/* File: rtl/pllc_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pllc_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_in,
  // Filtered levels
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // A change is accepted only once the second and third stages agree
  assign next_level = (stage2 & stage3) | (level & (stage2 ^ stage3));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule : pllc_sync3

`default_nettype wire

/* File: rtl/pllc_loop_ctrl.sv */
// Control logic of the fractional phase-locked loop with its register slave
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reference chosen from three clock sources
// - Output equals reference times integer plus sixteenths
// - Main crystal reference divided by two(div+1)
// - Disabled loop holds output clock in reset
// - Zero sixteenths means integer mode
// - Enable bit starts and stops loop
// - Stable only while enabled and locked
// - Nonzero lock time uses timer, else status
// - Wake-fast opens gate after startup
// - Normal mode: first edge at lock
// - Timer mode: first edge at timer zero
// - Without bypass, gate closes when unlocked after first lock
// - With bypass, gate stays open
// - Output clock set only by gate
// - Ratio rewrite clears then restores lock
// - Lock falling edge sets fail flag
module pllc_loop_ctrl (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  // Register bus
  input  wire pllc_pkg::pllc_axi_req_t s_axi_req,
  output var  pllc_pkg::pllc_axi_rsp_t s_axi_rsp,
  // Analog loop core status
  input  wire logic                    osc_active,
  input  wire logic                    core_lock,
  input  wire logic                    lock_timer_clock,
  // Analog loop core control
  output var  pllc_pkg::pllc_core_cfg_t core_cfg,
  output logic                         output_clock_gate,
  output logic                         output_clock_reset
);
  import pllc_pkg::*;

  // Register selector, shared by the read and write paths
  function automatic pllc_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
    if (addr == OFS_CONTROL_A) begin
      return PLLC_SEL_CTRL_A;
    end else if (addr == OFS_CONTROL_B) begin
      return PLLC_SEL_CTRL_B;
    end else if (addr == OFS_RATIO) begin
      return PLLC_SEL_RATIO;
    end else if (addr == OFS_STATE) begin
      return PLLC_SEL_STATE;
    end else if (addr == OFS_FLAG) begin
      return PLLC_SEL_FLAG;
    end else begin
      return PLLC_SEL_NONE;
    end
  endfunction : decode_sel

  // Byte-lane merge of a write into a stored image
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old_val & ~lanes) | (new_val & lanes);
  endfunction : merge_strb

  // Bus slave state
  logic                    aw_hold;
  logic [ADDR_W-1:0]       aw_addr;
  logic                    w_hold;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;

  // Register images
  logic [31:0]             control_a;
  logic [31:0]             control_b;
  logic [31:0]             ratio_reg;
  logic                    lock_fail_flag;

  // Loop state
  pllc_state_t             state;
  pllc_state_t             next_state;
  logic                    loop_locked;
  logic                    acq_done;
  logic [LOCK_TIME_SELECT_W-1:0]      lock_timer;
  logic [SETTLE_W-1:0]     settle_cnt;
  logic                    timer_clk_prev;

  // Synchronised loop-side inputs
  logic [2:0]              sync_level;
  logic                    osc_active_s;
  logic                    core_lock_s;
  logic                    timer_clk_s;

  pllc_sync3 #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (ref_clk),
    .rst_b    (rst_b),
    .async_in ({lock_timer_clock, core_lock, osc_active}),
    .level    (sync_level)
  );

  assign osc_active_s = sync_level[0];
  assign core_lock_s  = sync_level[1];
  assign timer_clk_s  = sync_level[2];

  // Register fields
  wire                     loop_on           = control_a[LOOP_ON_BIT];
  wire [1:0]               ref_source_select = control_b[REF_SEL_LSB +: 2];
  wire                     wake_fast         = control_b[WAKE_FAST_BIT];
  wire                     lock_ignore       = control_b[LOCK_IGNORE_BIT];
  wire [LOCK_TIME_SELECT_W-1:0]       lock_time_select  = control_b[LOCK_TIME_SELECT_LSB +: LOCK_TIME_SELECT_W];
  wire [DIV_W-1:0]         xosc_div          = control_b[DIV_LSB +: DIV_W];
  wire [RATIO_INT_W-1:0]   ratio_integer     = ratio_reg[RATIO_INT_LSB +: RATIO_INT_W];
  wire [FRAC_W-1:0]        ratio_sixteenths  = ratio_reg[RATIO_FRAC_LSB +: FRAC_W];

  // Bus handshakes
  wire aw_take = s_axi_req.awvalid & s_axi_rsp.awready;
  wire w_take  = s_axi_req.wvalid & s_axi_rsp.wready;
  wire ar_take = s_axi_req.arvalid & s_axi_rsp.arready;
  wire wr_do   = aw_hold & w_hold & ~s_axi_rsp.bvalid;
  wire b_done  = s_axi_rsp.bvalid & s_axi_req.bready;
  wire r_done  = s_axi_rsp.rvalid & s_axi_req.rready;

  wire next_aw_hold = (aw_hold | aw_take) & ~wr_do;
  wire next_w_hold  = (w_hold | w_take) & ~wr_do;
  wire next_bvalid  = wr_do | (s_axi_rsp.bvalid & ~b_done);
  wire next_rvalid  = ar_take | (s_axi_rsp.rvalid & ~r_done);

  wire pllc_sel_t wr_sel = decode_sel(aw_addr);
  wire pllc_sel_t rd_sel = decode_sel(s_axi_req.araddr);

  wire wr_ctrl_a = wr_do & (wr_sel == PLLC_SEL_CTRL_A);
  wire wr_ctrl_b = wr_do & (wr_sel == PLLC_SEL_CTRL_B);
  wire wr_ratio  = wr_do & (wr_sel == PLLC_SEL_RATIO);
  wire wr_flag   = wr_do & (wr_sel == PLLC_SEL_FLAG);
  wire wr_bad    = wr_do & (wr_sel == PLLC_SEL_NONE);
  wire rd_bad    = rd_sel == PLLC_SEL_NONE;

  wire [31:0] next_control_a = merge_strb(control_a, w_data, w_strb, CONTROL_A_MASK);
  wire [31:0] next_control_b = merge_strb(control_b, w_data, w_strb, CONTROL_B_MASK);
  wire [31:0] next_ratio_reg = merge_strb(ratio_reg, w_data, w_strb, RATIO_MASK);

  // Status word seen by software
  wire        frac_active = ratio_sixteenths != 4'h0;
  wire        freq_stable = loop_on & loop_locked;
  wire [31:0] state_word  = {26'h000_0000, state, frac_active,
                             freq_stable, output_clock_gate, loop_locked};

  wire [31:0] rd_word =
    (rd_sel == PLLC_SEL_CTRL_A) ? control_a :
    (rd_sel == PLLC_SEL_CTRL_B) ? control_b :
    (rd_sel == PLLC_SEL_RATIO)  ? ratio_reg :
    (rd_sel == PLLC_SEL_STATE)  ? state_word :
    (rd_sel == PLLC_SEL_FLAG)   ? {31'h0000_0000, lock_fail_flag} :
    32'h0000_0000;

  // Lock timer ticks on each rising edge of the filtered timer clock
  wire timer_tick  = timer_clk_s & ~timer_clk_prev;
  wire loop_start  = (state == PLLC_OFF) & loop_on;
  // A ratio rewrite while running restarts lock qualification
  wire ratio_bump  = wr_ratio & loop_on & (state != PLLC_OFF);
  wire timer_mode  = lock_time_select != 3'h0;

  // Lock source: own status or the expired user timer
  // In timer mode the core status is not used, before or after expiry
  wire lock_source = timer_mode ? (lock_timer == 3'h0) : core_lock_s;
  wire next_locked = (state != PLLC_OFF) & loop_on & ~ratio_bump &
                     (settle_cnt == 4'h0) & lock_source;
  wire lock_fall   = loop_locked & ~next_locked;
  wire next_acq    = (state == PLLC_RUN) & (acq_done | next_locked);

  // Gate: open in run; before first acquisition lock is not consulted,
  // so a wake-fast start runs on an unsettled output until first lock
  wire next_gate   = (next_state == PLLC_RUN) &
                     (lock_ignore | next_locked | ~next_acq);

  // Disabling the loop returns to off from any state at once
  always_comb begin
    next_state = state;
    case (state)
      PLLC_OFF: begin
        if (loop_on) begin
          next_state = PLLC_STARTUP;
        end
      end
      PLLC_STARTUP: begin
        if (!loop_on) begin
          next_state = PLLC_OFF;
        end else if (osc_active_s && wake_fast) begin
          next_state = PLLC_RUN;
        end else if (osc_active_s) begin
          next_state = PLLC_ACQUIRE;
        end
      end
      PLLC_ACQUIRE: begin
        if (!loop_on) begin
          next_state = PLLC_OFF;
        end else if (!timer_mode && next_locked) begin
          next_state = PLLC_RUN;
        end else if (timer_mode && next_locked) begin
          next_state = PLLC_RUN;
        end
      end
      PLLC_RUN: begin
        if (!loop_on) begin
          next_state = PLLC_OFF;
        end
      end
      default: begin
        next_state = PLLC_OFF;
      end
    endcase
  end

  // Bus slave
  // Each ready drops while its item is held, so no item is taken twice
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aw_hold   <= 1'b0;
      aw_addr   <= '0;
      w_hold    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      s_axi_rsp <= '0;
    end else begin
      aw_hold           <= next_aw_hold;
      w_hold            <= next_w_hold;
      s_axi_rsp.awready <= ~next_aw_hold;
      s_axi_rsp.wready  <= ~next_w_hold;
      s_axi_rsp.bvalid  <= next_bvalid;
      s_axi_rsp.rvalid  <= next_rvalid;
      s_axi_rsp.arready <= ~next_rvalid;
      if (aw_take) begin
        aw_addr <= s_axi_req.awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_req.wdata;
        w_strb <= s_axi_req.wstrb;
      end
      if (wr_do) begin
        s_axi_rsp.bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (ar_take) begin
        s_axi_rsp.rdata <= rd_word;
        s_axi_rsp.rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      control_a      <= CONTROL_A_RST;
      control_b      <= CONTROL_B_RST;
      ratio_reg      <= RATIO_RST;
    end else begin
      if (wr_ctrl_a) begin
        control_a <= next_control_a;
      end
      if (wr_ctrl_b) begin
        control_b <= next_control_b;
      end
      if (wr_ratio) begin
        ratio_reg <= next_ratio_reg;
      end
    end
  end

  // Lock-fail flag: a new falling edge wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lock_fail_flag <= 1'b0;
    end else if (lock_fall) begin
      lock_fail_flag <= 1'b1;
    end else if (wr_flag && w_strb[0] && w_data[FAIL_FLAG_BIT]) begin
      lock_fail_flag <= 1'b0;
    end
  end

  // Lock timer, loaded at enable and reloaded on a ratio rewrite
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lock_timer     <= 3'h0;
      timer_clk_prev <= 1'b0;
    end else begin
      timer_clk_prev <= timer_clk_s;
      if (loop_start || ratio_bump) begin
        lock_timer <= lock_time_select;
      end else if (timer_tick && lock_timer != 3'h0) begin
        lock_timer <= lock_timer - 3'h1;
      end
    end
  end

  // Settle counter holds lock off after a ratio rewrite
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      settle_cnt <= 4'h0;
    end else if (ratio_bump) begin
      settle_cnt <= SETTLE_W'(RATIO_SETTLE_CYC);
    end else if (settle_cnt != 4'h0) begin
      settle_cnt <= settle_cnt - 4'h1;
    end
  end

  // Loop sequencing and outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state              <= PLLC_OFF;
      loop_locked        <= 1'b0;
      acq_done           <= 1'b0;
      output_clock_gate  <= 1'b0;
      output_clock_reset <= 1'b1;
    end else begin
      state              <= next_state;
      loop_locked        <= next_locked;
      acq_done           <= next_acq;
      output_clock_gate  <= next_gate;
      output_clock_reset <= next_state == PLLC_OFF;
    end
  end

  // Registered copy of the settings for the analog loop core
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      core_cfg <= '0;
    end else begin
      core_cfg.loop_on           <= loop_on;
      core_cfg.ref_source_select <= pllc_ref_src_t'(ref_source_select);
      core_cfg.xosc_div          <= xosc_div;
      core_cfg.ratio_integer     <= ratio_integer;
      core_cfg.ratio_sixteenths  <= ratio_sixteenths;
      core_cfg.fractional_mode   <= frac_active;
    end
  end

endmodule : pllc_loop_ctrl

`default_nettype wire

/* File: test/pllc_loop_ctrl_assertions.sv */
// Port-level checker of the fractional loop controller
`timescale 1ns/1ps
`default_nettype none

module pllc_loop_ctrl_chk (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst_b,
  // Register bus
  input wire pllc_pkg::pllc_axi_req_t  s_axi_req,
  input wire pllc_pkg::pllc_axi_rsp_t  s_axi_rsp,
  // Loop core side
  input wire logic                     osc_active,
  input wire logic                     core_lock,
  input wire logic                     lock_timer_clock,
  input wire pllc_pkg::pllc_core_cfg_t core_cfg,
  input wire logic                     output_clock_gate,
  input wire logic                     output_clock_reset
);
  import pllc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  off_held_reset_a: assert property (!core_cfg.loop_on |->
    output_clock_reset && !output_clock_gate) else $error("output not held while off");
  enable_release_a: assert property (core_cfg.loop_on |-> !output_clock_reset)
    else $error("output reset while on");
  frac_mode_a: assert property (
    core_cfg.fractional_mode == (core_cfg.ratio_sixteenths != 4'h0)) else $error("mode wrong");
  gate_after_osc_a: assert property ($rose(output_clock_gate) |->
    $past(osc_active, 3)) else $error("gate opened before oscillator");
  write_answer_a: assert property (s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid
    && s_axi_rsp.wready && !s_axi_rsp.bvalid |-> ##2 s_axi_rsp.bvalid) else $error("no bvalid");
  read_answer_a: assert property (s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid)
    else $error("no rvalid");
  read_refuse_a: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
    else $error("arready during rvalid");
  err_data_zero_a: assert property (s_axi_rsp.rvalid && s_axi_rsp.rresp == RESP_SLVERR
    |-> s_axi_rsp.rdata == 32'h0) else $error("error read data not zero");

  cover property ($rose(output_clock_gate));
  cover property ($fell(output_clock_gate) && core_cfg.loop_on);
  cover property (s_axi_rsp.rvalid && s_axi_rsp.rresp == RESP_SLVERR);
endmodule : pllc_loop_ctrl_chk

bind pllc_loop_ctrl pllc_loop_ctrl_chk u_pllc_loop_ctrl_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .osc_active(osc_active),
  .core_lock(core_lock), .lock_timer_clock(lock_timer_clock), .core_cfg(core_cfg),
  .output_clock_gate(output_clock_gate), .output_clock_reset(output_clock_reset));

`default_nettype wire

/* File: test/pllc_core_model.sv */
// Behavioural loop core and timer clock source
`timescale 1ns/1ps
`default_nettype none

module pllc_core_model #(
  parameter int START = 20,
  parameter int LOCKD = 60
) (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic loop_on,
  input  wire logic hold_unlock,
  input  wire logic timer_en,
  // Core status
  output logic      osc_active,
  output logic      core_lock,
  output logic      lock_timer_clock
);
  int cnt = 0;
  initial osc_active = 1'b0;
  initial core_lock = 1'b0;
  initial lock_timer_clock = 1'b0;
  // Timer clock runs only while timer_en is set
  always #15625 if (timer_en) lock_timer_clock = !lock_timer_clock;
  always @(posedge ref_clk) begin
    cnt <= loop_on ? cnt + 1 : 0;
    osc_active <= loop_on && cnt > START;
    core_lock <= loop_on && cnt > START + LOCKD && !hold_unlock;
  end
endmodule : pllc_core_model

`default_nettype wire

/* File: test/test_fractional_pll_controller.sv */
// Self-checking bench of the fractional loop controller
`timescale 1ns/1ps
`default_nettype none

module test_fractional_pll_controller;
  import pllc_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst_b = 1'b0;
  pllc_axi_req_t  req = '0;
  pllc_axi_rsp_t  rsp;
  pllc_core_cfg_t cfg;
  logic           osc_active, core_lock, lock_timer_clock, gate, ocr;
  logic           hold_unlock = 1'b0;
  logic           timer_en = 1'b0;
  logic [31:0]    rv;
  int             err_total = 0;
  int             samples_checked = 0;
  int             cyc = 0;
  int             n;

  always #50 ref_clk = !ref_clk;
  pllc_loop_ctrl u_pllc_loop_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_req(req),
    .s_axi_rsp(rsp), .osc_active(osc_active), .core_lock(core_lock),
    .lock_timer_clock(lock_timer_clock), .core_cfg(cfg), .output_clock_gate(gate),
    .output_clock_reset(ocr));
  pllc_core_model u_pllc_core_model (.ref_clk(ref_clk), .loop_on(cfg.loop_on),
    .hold_unlock(hold_unlock), .timer_en(timer_en), .osc_active(osc_active),
    .core_lock(core_lock), .lock_timer_clock(lock_timer_clock));

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk(rsp.bresp === er, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge ref_clk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rv = rsp.rdata;
    req.rready <= 1'b0;
    chk(rsp.rresp === er, "read response");
  endtask : rd

  task automatic wait_gate(input logic v);
    n = 0;
    while (gate !== v && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_gate

  task automatic t_regs;
    logic [7:0] ofs [4] = '{OFS_CONTROL_A, OFS_CONTROL_B, OFS_RATIO, OFS_STATE};
    foreach (ofs[i]) begin
      rd(ofs[i], RESP_OKAY);
      chk(rv === 32'h0, "reset value");
    end
    wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h20, RESP_SLVERR);
    chk(rv === 32'h0, "unmapped data");
    wr(OFS_STATE, 32'hffff_ffff, RESP_OKAY);
    rd(OFS_STATE, RESP_OKAY);
    chk(rv === 32'h0, "read-only state");
    $display("done t_regs");
  endtask : t_regs

  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONTROL_B, {5'h0, 11'h7f0 + 11'(i), 14'h0, 2'(i)}, RESP_OKAY);
      @(posedge ref_clk);
      chk(cfg.ref_source_select === 2'(i), "reference select");
      chk(cfg.xosc_div === 11'h7f0 + 11'(i), "divider");
    end
    wr(OFS_RATIO, 32'hfff3_f5db, RESP_OKAY);
    rd(OFS_RATIO, RESP_OKAY);
    chk(rv === (32'hfff3_f5db & RATIO_MASK), "ratio readback");
    chk(cfg.ratio_integer === 12'h5db && cfg.ratio_sixteenths === 4'h3, "ratio");
    chk(cfg.fractional_mode === 1'b1, "fractional");
    wr(OFS_RATIO, 32'h0000_05db, RESP_OKAY);
    @(posedge ref_clk);
    chk(cfg.fractional_mode === 1'b0, "integer");
    $display("done t_cfg");
  endtask : t_cfg

  task automatic t_normal;
    wr(OFS_CONTROL_B, 32'h0, RESP_OKAY);
    wr(OFS_CONTROL_A, 32'h1, RESP_OKAY);
    @(posedge ref_clk);
    chk(ocr === 1'b0, "output reset released");
    wait_gate(1'b1);
    chk(core_lock === 1'b1 && gate === 1'b1, "first edge at lock");
    rd(OFS_STATE, RESP_OKAY);
    chk(rv[5:0] === 6'h37, "locked and stable");
    wr(OFS_RATIO, 32'h0001_0100, RESP_OKAY);
    rd(OFS_STATE, RESP_OKAY);
    chk(rv[0] === 1'b0, "lock cleared on ratio update");
    repeat (30) @(posedge ref_clk);
    rd(OFS_STATE, RESP_OKAY);
    chk(rv[0] === 1'b1, "lock restored");
    wr(OFS_FLAG, 32'h1, RESP_OKAY);
    hold_unlock <= 1'b1;
    wait_gate(1'b0);
    chk(n < 20, "gate off when unlocked");
    rd(OFS_FLAG, RESP_OKAY);
    chk(rv[0] === 1'b1, "lock fail flag");
    wr(OFS_FLAG, 32'h1, RESP_OKAY);
    rd(OFS_FLAG, RESP_OKAY);
    chk(rv[0] === 1'b0, "flag cleared");
    wr(OFS_CONTROL_A, 32'h0, RESP_OKAY);
    @(posedge ref_clk);
    chk(ocr === 1'b1 && gate === 1'b0, "output reset when off");
    $display("done t_normal");
  endtask : t_normal

  task automatic t_timer;
    hold_unlock <= 1'b1;
    wr(OFS_CONTROL_B, 32'h0000_0020, RESP_OKAY);
    wr(OFS_CONTROL_A, 32'h1, RESP_OKAY);
    wait_gate(1'b1);
    chk(n > 312 && n < 1400, "first edge at timer end");
    wr(OFS_CONTROL_A, 32'h0, RESP_OKAY);
    $display("done t_timer");
  endtask : t_timer

  task automatic t_fast;
    wr(OFS_CONTROL_B, 32'h0000_000c, RESP_OKAY);
    wr(OFS_CONTROL_A, 32'h1, RESP_OKAY);
    wait_gate(1'b1);
    chk(n < 60 && core_lock === 1'b0, "gate open after startup");
    hold_unlock <= 1'b0;
    repeat (90) @(posedge ref_clk);
    hold_unlock <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge ref_clk);
      chk(gate === 1'b1, "bypass keeps gate open");
    end
    wr(OFS_CONTROL_A, 32'h0, RESP_OKAY);
    wr(OFS_CONTROL_B, 32'h0000_0004, RESP_OKAY);
    wr(OFS_CONTROL_A, 32'h1, RESP_OKAY);
    wait_gate(1'b1);
    chk(n < 60 && core_lock === 1'b0, "fast gate open without bypass");
    repeat (20) @(posedge ref_clk);
    chk(gate === 1'b1, "gate held before first lock");
    hold_unlock <= 1'b0;
    repeat (90) @(posedge ref_clk);
    chk(gate === 1'b1 && core_lock === 1'b1, "gate open when locked");
    hold_unlock <= 1'b1;
    wait_gate(1'b0);
    chk(n < 20, "fast mode gate follows lock");
    wr(OFS_CONTROL_A, 32'h0, RESP_OKAY);
    $display("done t_fast");
  endtask : t_fast

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    timer_en <= 1'b1;
    t_regs();
    t_cfg();
    t_normal();
    t_timer();
    t_fast();
    conclude();
  end
endmodule : test_fractional_pll_controller

`default_nettype wire
